/* File: bridge_cmd_pkg.sv */
// constants, field positions and carriers for the primary command register
// assumes the primary bus decoder hands over requests on ref_clk
package bridge_cmd_pkg;
  localparam logic [5:0] cmd_dword_index = 6'h01;
  localparam logic [15:0] cmd_reset_value = 16'h0000;
  localparam logic [15:0] cmd_write_mask = 16'h0167;
  localparam int unsigned io_space_bit = 0;
  localparam int unsigned memory_space_bit = 1;
  localparam int unsigned bus_master_bit = 2;
  localparam int unsigned special_cycle_bit = 3;
  localparam int unsigned write_invalidate_bit = 4;
  localparam int unsigned palette_snoop_bit = 5;
  localparam int unsigned parity_response_bit = 6;
  localparam int unsigned stepping_bit = 7;
  localparam int unsigned system_error_bit = 8;
  localparam int unsigned back_to_back_bit = 9;
  localparam logic [9:0] palette_mask_addr = 10'h3c6;
  localparam logic [9:0] palette_read_addr = 10'h3c8;
  localparam logic [9:0] palette_data_addr = 10'h3c9;
  localparam logic [15:0] palette_upper_zero = 16'h0000;
  localparam logic pulse_idle = 1'h0;
  localparam logic pin_released = 1'h1;
  localparam logic [15:0] upper_half_read = 16'h0000;
  localparam logic [31:0] rdata_idle = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] dword_index;
    logic [3:0] byte_enable_n;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic is_mem;
    logic is_write;
    logic special_cycle;
    logic [31:0] addr;
    logic in_io_range;
    logic in_mem_range;
  } primary_txn_t;

  typedef struct packed {
    logic valid;
    logic is_io_or_mem;
    logic is_config;
    logic in_forward_range;
  } secondary_txn_t;

  typedef struct packed {
    logic master_active;
    logic data_parity_error;
    logic address_parity_error;
    logic other_system_error;
  } error_evt_t;
endpackage

/* File: bridge_primary_command_reg.sv */
// primary command register and the claim and error gating it steers
// assumes request inputs come from logic on ref_clk, one cycle per event
`timescale 1ns/10ps
`default_nettype none

// Function
// - all sixteen command bits clear to zero on reset.
// - bits 15 to 10 always read back as zero.
// - bit 9 reads zero; no fast back-to-back mastering.
// - system error line driven only when bit 8 is set.
// - bit 7 reads zero; no address or data stepping.
// - parity response clear blocks parity line, status set and address-parity system error.
// - parity response set drives parity line and may raise system error.
// - palette write is io write to 3c6, 3c8, 3c9 with upper half zero.
// - snoop clear ignores palette writes outside own io range.
// - snoop set claims palette writes and forwards them downstream.
// - bit 4 reads zero; write-invalidate only passed through.
// - bit 3 reads zero; special cycles ignored by io and memory claims, not by palette claims.
// - master enable clear blocks secondary claims and primary initiation.
// - master enable set claims secondary io and memory and initiates upstream.
// - configuration forwarding ignores master enable.
// - primary memory claimed only when memory space enable set.
// - primary io claimed only when io space enable set, except palette writes with snoop set.
// - data parity detected set only as master with parity response set.
module bridge_primary_command_reg (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire bridge_cmd_pkg::cfg_req_t cfg_req,
  output logic cfg_ack_r,
  output logic cfg_hit_r,
  output logic [31:0] cfg_rdata_r,
  input wire bridge_cmd_pkg::primary_txn_t primary_txn,
  output logic primary_claim_r,
  output logic primary_forward_r,
  input wire bridge_cmd_pkg::secondary_txn_t secondary_txn,
  output logic secondary_claim_r,
  output logic primary_initiate_r,
  output logic config_forward_r,
  input wire bridge_cmd_pkg::error_evt_t error_evt,
  output logic primary_parity_error_n,
  output logic primary_parity_error_oe_n,
  output logic primary_system_error_n,
  output logic primary_system_error_oe_n,
  output logic data_parity_detected_set_r,
  output logic [15:0] command_r
);
  // config request fields
  logic req_valid;
  logic req_write;
  logic [5:0] req_index;
  logic [1:0] req_lane_n;
  logic [1:0] lane_enable;
  logic [15:0] req_wdata;
  logic index_match;
  logic cfg_hit;
  logic cfg_read_hit;
  logic cfg_write_hit;
  logic [15:0] write_select;
  logic [15:0] command_nxt;
  logic [31:0] read_word;

  // command field enables
  logic io_space_enable;
  logic memory_space_enable;
  logic bus_master_enable;
  logic palette_snoop_enable;
  logic parity_response_enable;
  logic system_error_drive_enable;

  // primary transaction fields
  logic txn_valid;
  logic txn_io;
  logic txn_mem;
  logic txn_write;
  logic txn_special;
  logic [9:0] txn_low_addr;
  logic [15:0] txn_upper_addr;
  logic txn_in_io_range;
  logic txn_in_mem_range;
  logic match_mask_port;
  logic match_read_port;
  logic match_data_port;
  logic palette_low_match;
  logic upper_addr_zero;
  logic palette_write;
  logic io_claim;
  logic mem_claim;
  logic palette_claim;
  logic primary_claim;

  // secondary transaction fields
  logic sec_valid;
  logic sec_io_or_mem;
  logic sec_config;
  logic sec_in_range;
  logic secondary_claim;
  logic config_forward;

  // error event fields
  logic err_master;
  logic err_data_parity;
  logic err_address_parity;
  logic err_other;
  logic parity_drive;
  logic address_parity_report;
  logic system_error_drive;
  logic dp_detected;

  // next values of the output flops
  logic cfg_ack_nxt;
  logic cfg_hit_nxt;
  logic [31:0] cfg_rdata_nxt;
  logic primary_claim_nxt;
  logic primary_forward_nxt;
  logic secondary_claim_nxt;
  logic primary_initiate_nxt;
  logic config_forward_nxt;
  logic parity_error_n_nxt;
  logic parity_error_oe_n_nxt;
  logic system_error_n_nxt;
  logic system_error_oe_n_nxt;
  logic dp_set_nxt;

  // unpack the config request
  assign req_valid = cfg_req.valid;
  assign req_write = cfg_req.write;
  assign req_index = cfg_req.dword_index;
  assign req_lane_n = cfg_req.byte_enable_n[1:0];
  assign lane_enable = ~req_lane_n;
  assign req_wdata = cfg_req.wdata[15:0];

  // type 0 decode on dword index
  assign index_match = (req_index == bridge_cmd_pkg::cmd_dword_index);
  assign cfg_hit = req_valid && index_match;
  assign cfg_read_hit = cfg_hit && !req_write;
  assign cfg_write_hit = cfg_hit && req_write;

  // per-bit write through lane enable and writable mask
  for (genvar b = 0; b < 16; b++) begin : g_cmd_bit
    assign write_select[b] = cfg_write_hit && lane_enable[b / 8] &&
      bridge_cmd_pkg::cmd_write_mask[b];
    assign command_nxt[b] = write_select[b] ? req_wdata[b] : command_r[b];
  end

  // command field taps
  assign io_space_enable = command_r[bridge_cmd_pkg::io_space_bit];
  assign memory_space_enable = command_r[bridge_cmd_pkg::memory_space_bit];
  assign bus_master_enable = command_r[bridge_cmd_pkg::bus_master_bit];
  assign palette_snoop_enable = command_r[bridge_cmd_pkg::palette_snoop_bit];
  assign parity_response_enable = command_r[bridge_cmd_pkg::parity_response_bit];
  assign system_error_drive_enable = command_r[bridge_cmd_pkg::system_error_bit];

  // unpack the primary transaction
  assign txn_valid = primary_txn.valid;
  assign txn_io = primary_txn.is_io;
  assign txn_mem = primary_txn.is_mem;
  assign txn_write = primary_txn.is_write;
  assign txn_special = primary_txn.special_cycle;
  assign txn_low_addr = primary_txn.addr[9:0];
  assign txn_upper_addr = primary_txn.addr[31:16];
  assign txn_in_io_range = primary_txn.in_io_range;
  assign txn_in_mem_range = primary_txn.in_mem_range;

  // palette write match, address bits 15:10 not decoded
  assign match_mask_port = (txn_low_addr == bridge_cmd_pkg::palette_mask_addr);
  assign match_read_port = (txn_low_addr == bridge_cmd_pkg::palette_read_addr);
  assign match_data_port = (txn_low_addr == bridge_cmd_pkg::palette_data_addr);
  assign palette_low_match = match_mask_port || match_read_port || match_data_port;
  assign upper_addr_zero = (txn_upper_addr == bridge_cmd_pkg::palette_upper_zero);
  assign palette_write = txn_valid && txn_io && txn_write && palette_low_match &&
    upper_addr_zero;

  // primary claims
  assign io_claim = txn_valid && txn_io && io_space_enable && txn_in_io_range &&
    !txn_special;
  assign mem_claim = txn_valid && txn_mem && memory_space_enable && txn_in_mem_range &&
    !txn_special;
  assign palette_claim = palette_write && palette_snoop_enable;
  assign primary_claim = io_claim || mem_claim || palette_claim;

  // unpack the secondary transaction
  assign sec_valid = secondary_txn.valid;
  assign sec_io_or_mem = secondary_txn.is_io_or_mem;
  assign sec_config = secondary_txn.is_config;
  assign sec_in_range = secondary_txn.in_forward_range;
  assign secondary_claim = sec_valid && sec_io_or_mem && sec_in_range &&
    bus_master_enable;
  assign config_forward = sec_valid && sec_config;

  // unpack the error events
  assign err_master = error_evt.master_active;
  assign err_data_parity = error_evt.data_parity_error;
  assign err_address_parity = error_evt.address_parity_error;
  assign err_other = error_evt.other_system_error;
  assign parity_drive = err_data_parity && parity_response_enable;
  assign address_parity_report = err_address_parity && parity_response_enable;
  assign system_error_drive = system_error_drive_enable &&
    (address_parity_report || err_other);
  assign dp_detected = err_master && err_data_parity && parity_response_enable;

  // next values of the output flops
  assign read_word = {bridge_cmd_pkg::upper_half_read, command_r};
  assign cfg_ack_nxt = cfg_hit;
  assign cfg_hit_nxt = cfg_read_hit;
  assign cfg_rdata_nxt = cfg_read_hit ? read_word : bridge_cmd_pkg::rdata_idle;
  assign primary_claim_nxt = primary_claim;
  assign primary_forward_nxt = primary_claim;
  assign secondary_claim_nxt = secondary_claim;
  assign primary_initiate_nxt = secondary_claim;
  assign config_forward_nxt = config_forward;
  assign parity_error_n_nxt = ~parity_drive;
  assign parity_error_oe_n_nxt = ~parity_drive;
  assign system_error_n_nxt = ~system_error_drive;
  assign system_error_oe_n_nxt = ~system_error_drive;
  assign dp_set_nxt = dp_detected;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      command_r <= bridge_cmd_pkg::cmd_reset_value;
    end else if (clk_en) begin
      command_r <= command_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ack_r <= bridge_cmd_pkg::pulse_idle;
    end else if (clk_en) begin
      cfg_ack_r <= cfg_ack_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_hit_r <= bridge_cmd_pkg::pulse_idle;
    end else if (clk_en) begin
      cfg_hit_r <= cfg_hit_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata_r <= bridge_cmd_pkg::rdata_idle;
    end else if (clk_en) begin
      cfg_rdata_r <= cfg_rdata_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      primary_claim_r <= bridge_cmd_pkg::pulse_idle;
    end else if (clk_en) begin
      primary_claim_r <= primary_claim_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      primary_forward_r <= bridge_cmd_pkg::pulse_idle;
    end else if (clk_en) begin
      primary_forward_r <= primary_forward_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      secondary_claim_r <= bridge_cmd_pkg::pulse_idle;
    end else if (clk_en) begin
      secondary_claim_r <= secondary_claim_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      primary_initiate_r <= bridge_cmd_pkg::pulse_idle;
    end else if (clk_en) begin
      primary_initiate_r <= primary_initiate_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      config_forward_r <= bridge_cmd_pkg::pulse_idle;
    end else if (clk_en) begin
      config_forward_r <= config_forward_nxt;
    end
  end

  // open-drain pins: value low, enable low while driving
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      primary_parity_error_n <= bridge_cmd_pkg::pin_released;
      primary_parity_error_oe_n <= bridge_cmd_pkg::pin_released;
    end else if (clk_en) begin
      primary_parity_error_n <= parity_error_n_nxt;
      primary_parity_error_oe_n <= parity_error_oe_n_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      primary_system_error_n <= bridge_cmd_pkg::pin_released;
      primary_system_error_oe_n <= bridge_cmd_pkg::pin_released;
    end else if (clk_en) begin
      primary_system_error_n <= system_error_n_nxt;
      primary_system_error_oe_n <= system_error_oe_n_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_parity_detected_set_r <= bridge_cmd_pkg::pulse_idle;
    end else if (clk_en) begin
      data_parity_detected_set_r <= dp_set_nxt;
    end
  end
endmodule

`default_nettype wire

/* File: bridge_cmd_assertions.sv */
// port checker for the primary command register
// assumes one ref_clk domain, async active-low reset_n
`timescale 1ns/10ps
`default_nettype none
module bridge_cmd_assertions (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire bridge_cmd_pkg::cfg_req_t cfg_req,
  input wire logic cfg_ack_r,
  input wire bridge_cmd_pkg::primary_txn_t primary_txn,
  input wire logic primary_claim_r,
  input wire logic secondary_claim_r,
  input wire logic primary_initiate_r,
  input wire bridge_cmd_pkg::error_evt_t error_evt,
  input wire logic primary_parity_error_oe_n,
  input wire logic primary_system_error_oe_n,
  input wire logic data_parity_detected_set_r,
  input wire logic [15:0] command_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic pal = clk_en && primary_txn.valid && primary_txn.is_io && primary_txn.is_write
    && primary_txn.addr[9:0] == 10'h3c8 && primary_txn.addr[31:16] == 16'h0000;
  fixed_bits_a: assert property ((command_r & 16'hfe98) == 16'h0000)
    else $error("fixed bits set");
  cfg_ack_a: assert property (clk_en && cfg_req.valid && cfg_req.dword_index == 6'h01
    |=> cfg_ack_r) else $error("ack missing");
  serr_gate_a: assert property (!primary_system_error_oe_n |-> $past(command_r[8]))
    else $error("serr driven");
  perr_drive_a: assert property (clk_en && error_evt.data_parity_error && command_r[6]
    |=> !primary_parity_error_oe_n) else $error("perr missing");
  perr_gate_a: assert property (!primary_parity_error_oe_n
    |-> $past(command_r[6] && error_evt.data_parity_error)) else $error("perr driven");
  palette_claim_a: assert property (pal && command_r[5] |=> primary_claim_r)
    else $error("palette not claimed");
  master_gate_a: assert property (secondary_claim_r |-> $past(command_r[2])
    && primary_initiate_r) else $error("secondary claim");
  dp_set_a: assert property (data_parity_detected_set_r
    |-> $past(error_evt.master_active && command_r[6])) else $error("dp set");
  palette_c: cover property (pal && command_r[5]);
  serr_c: cover property (!primary_system_error_oe_n);
  dp_set_c: cover property (data_parity_detected_set_r);
endmodule
bind bridge_primary_command_reg bridge_cmd_assertions u_chk (.ref_clk, .reset_n, .clk_en,
  .cfg_req, .cfg_ack_r, .primary_txn, .primary_claim_r, .secondary_claim_r,
  .primary_initiate_r, .error_evt, .primary_parity_error_oe_n,
  .primary_system_error_oe_n, .data_parity_detected_set_r, .command_r);
`default_nettype wire

/* File: cfg_host.sv */
// config host model on the primary type 0 path
// assumes callers use xfer; drives on falling ref_clk
`timescale 1ns/10ps
`default_nettype none
module cfg_host (
  input wire logic ref_clk,
  output var bridge_cmd_pkg::cfg_req_t cfg_req
);
  initial cfg_req = '0;
  task automatic xfer(input logic w, input logic [5:0] i, input logic [3:0] b,
    input logic [31:0] d);
    @(negedge ref_clk);
    cfg_req = {1'b1, w, i, b, d};
    @(negedge ref_clk);
    cfg_req = {1'b0, 1'b0, ~i, 4'hf, ~d};
  endtask
endmodule
`default_nettype wire

/* File: bridge_primary_command_reg_tb.sv */
// bench for the primary command register
// assumes cfg_host and the bound checker
`timescale 1ns/10ps
`default_nettype none
module bridge_primary_command_reg_tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  bridge_cmd_pkg::cfg_req_t cq;
  bridge_cmd_pkg::primary_txn_t pt = '0;
  bridge_cmd_pkg::secondary_txn_t st = '0;
  bridge_cmd_pkg::error_evt_t ev = '0;
  logic ack, hit, pc, pf, sc, pi, cf, pe, peo, se, seo, dps;
  logic [31:0] rd;
  logic [15:0] cmd;
  int err_total = 0;
  int check_count = 0;
  always #5 ref_clk = ~ref_clk;
  cfg_host u_host (.ref_clk(ref_clk), .cfg_req(cq));
  bridge_primary_command_reg u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(ce),
    .cfg_req(cq), .cfg_ack_r(ack), .cfg_hit_r(hit), .cfg_rdata_r(rd), .primary_txn(pt),
    .primary_claim_r(pc), .primary_forward_r(pf), .secondary_txn(st),
    .secondary_claim_r(sc), .primary_initiate_r(pi), .config_forward_r(cf),
    .error_evt(ev), .primary_parity_error_n(pe), .primary_parity_error_oe_n(peo),
    .primary_system_error_n(se), .primary_system_error_oe_n(seo),
    .data_parity_detected_set_r(dps), .command_r(cmd));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [31:0] d, input logic [3:0] b);
    u_host.xfer(1'b1, 6'h01, b, d);
  endtask
  task automatic rdc(input logic [15:0] e);
    u_host.xfer(1'b0, 6'h01, 4'h0, 32'h0);
    chk({hit, 15'h0, rd[15:0]}, {1'b1, 15'h0, e});
    chk({16'h0, rd[31:16]}, 32'h0);
  endtask
  task automatic ps(input logic [3:0] k, input logic [31:0] a, input logic e);
    @(negedge ref_clk);
    pt = {1'b1, k[3], k[2], 1'b1, k[1], a, k[0], k[0]};
    @(negedge ref_clk);
    pt.valid = 1'b0;
    chk({30'h0, pc, pf}, {30'h0, e, e});
  endtask
  task automatic ss(input logic [2:0] k, input logic [2:0] e);
    @(negedge ref_clk);
    st = {1'b1, k};
    @(negedge ref_clk);
    st.valid = 1'b0;
    chk({29'h0, sc, pi, cf}, {29'h0, e});
  endtask
  task automatic es(input logic [3:0] k, input logic [2:0] e);
    @(negedge ref_clk);
    ev = k;
    @(negedge ref_clk);
    chk({27'h0, pe, peo, se, seo, dps}, {27'h0, e[2], e[2], e[1], e[1], e[0]});
    ev = '0;
  endtask
  task automatic t_regs;
    rdc(16'h0000);
    wr(32'hffff_ffff, 4'h0);
    rdc(16'h0167);
    u_host.xfer(1'b1, 6'h02, 4'h0, 32'h0);
    chk({31'h0, ack}, 32'h0);
    wr(32'h0, 4'he);
    rdc(16'h0100);
    $display("regs test done");
  endtask
  task automatic t_claim;
    for (int c = 0; c < 4; c++) begin
      wr({30'h0, c[1:0]}, 4'h0);
      ps(4'b1001, 32'h0000_1000, c[0]);
      ps(4'b0101, 32'h8000_0000, c[1]);
    end
    ps(4'b1000, 32'h0000_1000, 1'b0);
    ps(4'b0111, 32'h0000_1000, 1'b0);
    wr(32'h20, 4'h0);
    ps(4'b1000, 32'h0000_fbc6, 1'b1);
    ps(4'b1000, 32'h0000_03c8, 1'b1);
    ps(4'b1000, 32'h0000_ffc9, 1'b1);
    ps(4'b1000, 32'h0001_03c8, 1'b0);
    ps(4'b1000, 32'h0000_03c7, 1'b0);
    wr(32'h01, 4'h0);
    ps(4'b1000, 32'h0000_03c8, 1'b0);
    ps(4'b1001, 32'h0000_03c8, 1'b1);
    $display("claim test done");
  endtask
  task automatic t_sec;
    ss(3'b101, 3'b000);
    ss(3'b010, 3'b001);
    wr(32'h04, 4'h0);
    ss(3'b101, 3'b110);
    ss(3'b010, 3'b001);
    $display("secondary test done");
  endtask
  task automatic t_err;
    es(4'b1110, 3'b110);
    wr(32'h40, 4'h0);
    es(4'b1100, 3'b011);
    es(4'b0100, 3'b010);
    es(4'b0010, 3'b110);
    wr(32'h140, 4'h0);
    es(4'b0010, 3'b100);
    wr(32'h100, 4'h0);
    es(4'b0010, 3'b110);
    es(4'b0001, 3'b100);
    $display("error test done");
  endtask
  task automatic t_hold;
    wr(32'h0000_0167, 4'h0);
    ce = 1'b0;
    wr(32'h0000_0000, 4'h0);
    ce = 1'b1;
    rdc(16'h0167);
    @(negedge ref_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    rdc(16'h0000);
    $display("hold and reset test done");
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    t_regs;
    t_claim;
    t_sec;
    t_err;
    t_hold;
    give_verdict;
  end
  initial begin
    #200000;
    err_total++;
    give_verdict;
  end
endmodule
`default_nettype wire
